// File: design/tcb_timer_clock_baud.sv
`timescale 1ns/1ns
// Summary of operation
// - baud comes from timer 1 as 8-bit auto-reload counter
// - transmit uses timer1 low byte; receive uses hidden copy
// - both counter overflows divided by two into bit clocks
// - receive copy runs with timer 1, reloads from reload byte
// - start condition on receive pin forces receive copy reload
// - overflow rate is timer clock over 256 minus reload byte
// - timer 1 clock: core clock if select set, else prescaled; counter mode ignores
// - timer 0 clock same, ignored when timer 0 counter select set
// - prescale field: /12, /4, /48, or external /8
// - external divide-by-8 is synchronised before use
// - split mode: timer2 high byte core clock if set, else alternate
// - timer2 (low byte) core clock if set, else alternate clock
// - top two bits read zero, software writes zero
// - core clock may keep running while external clock drives timer 1
module tcb_timer_clock_baud (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  input wire logic extDiv8Level,
  input wire logic timer1ExternalInput,
  input wire logic timer0ExternalInput,
  input wire logic timer2AltTick,
  input wire logic timer1Run,
  input wire logic timer1CounterSelect,
  input wire logic timer0CounterSelect,
  input wire logic timer2SplitMode,
  input wire logic [7:0] timer1ReloadByte,
  input wire logic serialRxPin,
  input wire logic rxStartDetect,
  output logic [7:0] timer1LowByte,
  output logic timer1Overflow,
  output logic txBitTick,
  output logic rxBitTick,
  output logic timer0Tick,
  output logic timer2LowTick,
  output logic timer2HighTick
);
  logic [7:0] clockSelect_q;
  logic prescaleTick;
  logic [2:0] t1Sync_q;
  logic [2:0] t0Sync_q;
  logic t1Seen_q;
  logic t0Seen_q;
  logic t1Pin;
  logic t0Pin;
  logic t1Tick;
  logic [7:0] rxCount_q;
  logic txHalf_q;
  logic rxHalf_q;
  logic rxOverflow;
  logic unusedRxPin;

  assign unusedRxPin = serialRxPin;

  //////////////////////////////////////////////////////////////////////////
  // clock control register
  always_ff @(posedge clock) begin
    if (reset) begin
      clockSelect_q <= tcb_pkg::CLOCK_SELECT_RESET;
      regReadData <= 8'h00;
    end else if (clockEnable) begin
      if (regWrite && regAddr == tcb_pkg::CLOCK_SELECT_ADDR) begin
        clockSelect_q <= regWriteData & tcb_pkg::WRITABLE_MASK;
      end
      if (regRead && regAddr == tcb_pkg::CLOCK_SELECT_ADDR) begin
        regReadData <= clockSelect_q & tcb_pkg::WRITABLE_MASK;
      end else begin
        regReadData <= 8'h00;
      end
    end
  end

  tcb_prescaler prescaler (
    .clock(clock),
    .reset(reset),
    .clockEnable(clockEnable),
    .prescaleSelect(clockSelect_q[tcb_pkg::PRESCALE_HI_BIT:tcb_pkg::PRESCALE_LO_BIT]),
    .extDiv8Level(extDiv8Level),
    .prescaleTick(prescaleTick)
  );

  //////////////////////////////////////////////////////////////////////////
  // external timer pins: three stages, edge from stages two and three
  always_ff @(posedge clock) begin
    if (reset) begin
      t1Sync_q <= 3'h0;
      t0Sync_q <= 3'h0;
      t1Seen_q <= 1'b0;
      t0Seen_q <= 1'b0;
    end else if (clockEnable) begin
      t1Sync_q <= {t1Sync_q[1:0], timer1ExternalInput};
      t0Sync_q <= {t0Sync_q[1:0], timer0ExternalInput};
      t1Seen_q <= 1'b1;
      t0Seen_q <= 1'b1;
    end
  end

  // counters count falling edges of their external input
  assign t1Pin = ~t1Sync_q[1] & t1Sync_q[2] & t1Seen_q;
  assign t0Pin = ~t0Sync_q[1] & t0Sync_q[2] & t0Seen_q;

  // core clock ticks every cycle, so timer 1 runs without touching core clock
  assign t1Tick = timer1CounterSelect ? t1Pin :
    (clockSelect_q[tcb_pkg::TIMER1_CORE_CLOCK_BIT] ? 1'b1 : prescaleTick);

  //////////////////////////////////////////////////////////////////////////
  // timer clock enables for timers 0 and 2
  always_ff @(posedge clock) begin
    if (reset) begin
      timer0Tick <= 1'b0;
      timer2LowTick <= 1'b0;
      timer2HighTick <= 1'b0;
    end else if (clockEnable) begin
      timer0Tick <= timer0CounterSelect ? t0Pin :
        (clockSelect_q[tcb_pkg::TIMER0_CORE_CLOCK_BIT] ? 1'b1 : prescaleTick);
      timer2LowTick <= clockSelect_q[tcb_pkg::TIMER2_LOW_BIT] ? 1'b1 : timer2AltTick;
      timer2HighTick <= (timer2SplitMode && clockSelect_q[tcb_pkg::TIMER2_HIGH_BIT]) ?
        1'b1 : timer2AltTick;
    end else begin
      timer0Tick <= 1'b0;
      timer2LowTick <= 1'b0;
      timer2HighTick <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // timer 1 low byte, 8-bit auto-reload
  always_ff @(posedge clock) begin
    if (reset) begin
      timer1LowByte <= 8'h00;
      timer1Overflow <= 1'b0;
    end else if (clockEnable && timer1Run && t1Tick) begin
      if (timer1LowByte == 8'hff) begin
        timer1LowByte <= timer1ReloadByte;
        timer1Overflow <= 1'b1;
      end else begin
        timer1LowByte <= timer1LowByte + 8'h01;
        timer1Overflow <= 1'b0;
      end
    end else begin
      timer1Overflow <= 1'b0;
    end
  end

  // hidden receive copy of the low byte
  assign rxOverflow = rxCount_q == 8'hff;

  always_ff @(posedge clock) begin
    if (reset) begin
      rxCount_q <= 8'h00;
    end else if (clockEnable) begin
      if (rxStartDetect) begin
        rxCount_q <= timer1ReloadByte;
      end else if (timer1Run && t1Tick) begin
        rxCount_q <= rxOverflow ? timer1ReloadByte : rxCount_q + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bit clocks: every second overflow
  always_ff @(posedge clock) begin
    if (reset) begin
      txHalf_q <= 1'b0;
      rxHalf_q <= 1'b0;
      txBitTick <= 1'b0;
      rxBitTick <= 1'b0;
    end else if (clockEnable) begin
      txBitTick <= 1'b0;
      rxBitTick <= 1'b0;
      if (timer1Overflow) begin
        txHalf_q <= ~txHalf_q;
        txBitTick <= txHalf_q;
      end
      if (rxStartDetect) begin
        rxHalf_q <= 1'b0; // restart phase so first bit time is whole
      end else if (timer1Run && t1Tick && rxOverflow) begin
        rxHalf_q <= ~rxHalf_q;
        rxBitTick <= rxHalf_q;
      end
    end else begin
      txBitTick <= 1'b0;
      rxBitTick <= 1'b0;
    end
  end

  a_reload_on_wrap: assert property (@(posedge clock) disable iff (reset)
    clockEnable && timer1Run && t1Tick && timer1LowByte == 8'hff
    |=> timer1Overflow && timer1LowByte == $past(timer1ReloadByte))
    else $error("low byte did not reload on overflow");

  a_rx_start_reload: assert property (@(posedge clock) disable iff (reset)
    clockEnable && rxStartDetect |=> rxCount_q == $past(timer1ReloadByte))
    else $error("receive copy not reloaded on start");

  a_reserved_zero: assert property (@(posedge clock) disable iff (reset)
    regReadData[7:6] == 2'h0)
    else $error("reserved bits read nonzero");

  a_tx_halving: assert property (@(posedge clock) disable iff (reset)
    txBitTick |-> $past(timer1Overflow) && $past(txHalf_q))
    else $error("transmit bit clock not on second overflow");

  a_t1_core_clock: assert property (@(posedge clock) disable iff (reset)
    clockEnable && timer1Run && !timer1CounterSelect
    && clockSelect_q[tcb_pkg::TIMER1_CORE_CLOCK_BIT] && timer1LowByte != 8'hff
    |=> timer1LowByte == $past(timer1LowByte) + 8'h01)
    else $error("timer 1 not counting on core clock");

  a_t0_select: assert property (@(posedge clock) disable iff (reset)
    clockEnable && !timer0CounterSelect && clockSelect_q[tcb_pkg::TIMER0_CORE_CLOCK_BIT]
    |=> timer0Tick)
    else $error("timer 0 tick missing on core clock");

  a_t2_low: assert property (@(posedge clock) disable iff (reset)
    clockEnable && clockSelect_q[tcb_pkg::TIMER2_LOW_BIT] |=> timer2LowTick)
    else $error("timer 2 low tick missing");

  a_t2_high: assert property (@(posedge clock) disable iff (reset)
    clockEnable && !timer2SplitMode |=> timer2HighTick == $past(timer2AltTick))
    else $error("timer 2 high byte clock wrong outside split mode");

  a_rx_stop: assert property (@(posedge clock) disable iff (reset)
    clockEnable && !timer1Run && !rxStartDetect |=> $stable(rxCount_q))
    else $error("receive copy ran while timer 1 stopped");
endmodule

// File: pkg/tcb_pkg.sv
package tcb_pkg;
  localparam logic [7:0] CLOCK_SELECT_ADDR = 8'h8e;
  localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
  localparam int TIMER2_HIGH_BIT = 5;
  localparam int TIMER2_LOW_BIT = 4;
  localparam int TIMER1_CORE_CLOCK_BIT = 3;
  localparam int TIMER0_CORE_CLOCK_BIT = 2;
  localparam int PRESCALE_HI_BIT = 1;
  localparam int PRESCALE_LO_BIT = 0;
  localparam logic [7:0] WRITABLE_MASK = 8'h3f;
  localparam logic [1:0] PRESCALE_DIV12 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
  localparam logic [1:0] PRESCALE_DIV48 = 2'h2;
  localparam logic [1:0] PRESCALE_EXT8 = 2'h3;
  localparam logic [5:0] DIV12_LAST = 6'h0b;
  localparam logic [5:0] DIV4_LAST = 6'h03;
  localparam logic [5:0] DIV48_LAST = 6'h2f;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;
endpackage

// File: design/tcb_prescaler.sv
`timescale 1ns/1ns
// shared timer 0/1 prescaler; output is a one-cycle tick on the core clock
module tcb_prescaler (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic [1:0] prescaleSelect,
  input wire logic extDiv8Level,
  output logic prescaleTick
);
  logic [5:0] divCount_q;
  logic [2:0] extSync_q;
  logic extSeen_q;
  logic extRise;

  assign extRise = extSync_q[1] & ~extSync_q[2] & extSeen_q;

  function automatic logic [5:0] lastCount(input logic [1:0] sel);
    case (sel)
      tcb_pkg::PRESCALE_DIV12: lastCount = tcb_pkg::DIV12_LAST;
      tcb_pkg::PRESCALE_DIV4: lastCount = tcb_pkg::DIV4_LAST;
      default: lastCount = tcb_pkg::DIV48_LAST;
    endcase
  endfunction

  // external level passes three stages; edge taken from stages two and three
  always_ff @(posedge clock) begin
    if (reset) begin
      extSync_q <= 3'h0;
      extSeen_q <= 1'b0;
    end else if (clockEnable) begin
      extSync_q <= {extSync_q[1:0], extDiv8Level};
      extSeen_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      divCount_q <= 6'h00;
      prescaleTick <= 1'b0;
    end else if (clockEnable) begin
      if (prescaleSelect == tcb_pkg::PRESCALE_EXT8) begin
        divCount_q <= 6'h00;
        prescaleTick <= extRise;
      end else if (divCount_q >= lastCount(prescaleSelect)) begin
        divCount_q <= 6'h00;
        prescaleTick <= 1'b1;
      end else begin
        divCount_q <= divCount_q + 6'h01;
        prescaleTick <= 1'b0;
      end
    end else begin
      prescaleTick <= 1'b0;
    end
  end

  a_tick_single: assert property (@(posedge clock) disable iff (reset)
    prescaleSelect == tcb_pkg::PRESCALE_DIV4 && $stable(prescaleSelect) && clockEnable
    && prescaleTick ##1 clockEnable |-> !prescaleTick)
    else $error("prescale tick lasted more than one cycle");
endmodule

// File: dv/tcb_serial_model.sv
`timescale 1ns/1ns
// receive-side stand-in: a falling receive pin is reported as a start bit
module tcb_serial_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic serialRxPin,
  output logic rxStartDetect
);
  logic rxPin_q;
  // reset parks the pin history high, so a pin already low at release is reported as a start
  always_ff @(posedge clock) begin
    rxPin_q <= reset | serialRxPin;
    rxStartDetect <= !reset && rxPin_q && !serialRxPin;
  end
endmodule

// File: dv/tcb_timer_clock_baud_bench.sv
`timescale 1ns/1ns
module tcb_timer_clock_baud_bench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic regWrite = 1'b0, regRead = 1'b0, extLevel = 1'b0, t0Sel = 1'b0, altTick = 1'b0;
  logic t1Run = 1'b0, split = 1'b0, rxPin = 1'b1;
  logic t1Sel = 1'b0, t1In = 1'b1, cke = 1'b1;
  logic [7:0] lowByte;
  logic [7:0] regAddr = 8'h00, regWriteData = 8'h00, reloadByte = 8'h00, regReadData;
  logic rxStart, t1Ovf, txTick, rxTick, t0Tick, t2Low, t2High;
  int mismatches = 0, check_count = 0, extCount = 0, n;
  int divs[3] = '{12, 4, 48};
  always #5 clock = ~clock;
  // external /8 square wave with a 10-cycle period, unrelated to any divider
  always @(negedge clock) begin
    extCount <= extCount + 1;
    if (extCount % 5 == 4) extLevel <= ~extLevel;
  end
  tcb_timer_clock_baud tcb_timer_clock_baud_i (.clock(clock), .reset(reset),
    .clockEnable(cke), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWriteData(regWriteData), .regReadData(regReadData), .extDiv8Level(extLevel),
    .timer1ExternalInput(t1In), .timer0ExternalInput(1'b1), .timer2AltTick(altTick),
    .timer1Run(t1Run), .timer1CounterSelect(t1Sel), .timer0CounterSelect(t0Sel),
    .timer2SplitMode(split), .timer1ReloadByte(reloadByte), .serialRxPin(rxPin),
    .rxStartDetect(rxStart), .timer1LowByte(lowByte), .timer1Overflow(t1Ovf),
    .txBitTick(txTick), .rxBitTick(rxTick), .timer0Tick(t0Tick),
    .timer2LowTick(t2Low), .timer2HighTick(t2High));
  tcb_serial_model tcb_serial_model_i (.clock(clock), .reset(reset),
    .serialRxPin(rxPin), .rxStartDetect(rxStart));
  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input string what, input logic [15:0] e, input logic [15:0] got);
    check_count++;
    if (got !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, got);
    end
  endtask
  task writeReg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
  endtask
  task expectReg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    check("register read", {8'h00, e}, {8'h00, regReadData});
  endtask
  function logic pick(input int s);
    case (s)
      0: pick = t1Ovf;
      1: pick = txTick;
      default: pick = rxTick;
    endcase
  endfunction
  task waitPulse(input int s, output int c);
    c = 0;
    do begin
      @(negedge clock);
      c++;
    end while (pick(s) !== 1'b1 && c < 400);
    if (c >= 400) begin
      check("pulse wait", 16'h0001, 16'h0000);
      results;
    end
  endtask
  task period(input int s, input int e, input string what);
    int c;
    waitPulse(s, c);
    waitPulse(s, c);
    check(what, 16'(e), 16'(c));
  endtask
  task settle;
    repeat (3) @(negedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clock);
    reset = 1'b0;
    expectReg(8'h8e, 8'h00);
    writeReg(8'h8f, 8'hff);
    expectReg(8'h8f, 8'h00);
    writeReg(8'h8e, 8'hff);
    expectReg(8'h8e, 8'h3f);
    $display("register test done");
    reloadByte = 8'hfc;
    t1Run = 1'b1;
    writeReg(8'h8e, 8'h08);
    period(0, 4, "overflow core clock");
    check("low byte reload", 16'h00fc, {8'h00, lowByte});
    // clock enable low must hold the counter where it stands
    cke = 1'b0;
    repeat (5) @(negedge clock);
    check("low byte frozen", 16'h00fc, {8'h00, lowByte});
    cke = 1'b1;
    period(1, 8, "tx bit tick");
    period(2, 8, "rx bit tick");
    reloadByte = 8'hf0;
    period(2, 32, "rx bit tick slow");
    // a start 10 cycles after a tick must restart the rx phase, not wait 22
    repeat (9) @(negedge clock);
    rxPin = 1'b0;
    waitPulse(2, n);
    check("rx restart delay", 16'h0001, {15'h0000, n >= 33 && n <= 40});
    rxPin = 1'b1;
    $display("baud test done");
    reloadByte = 8'hff;
    for (int i = 0; i < 3; i++) begin
      writeReg(8'h8e, 8'(i));
      period(0, divs[i], "prescaled overflow");
    end
    writeReg(8'h8e, 8'h03);
    period(0, 10, "external overflow");
    $display("prescale test done");
    writeReg(8'h8e, 8'h04);
    settle;
    check("timer0 tick", 16'h0001, {15'h0000, t0Tick});
    t0Sel = 1'b1;
    settle;
    check("timer0 counter mode", 16'h0000, {15'h0000, t0Tick});
    writeReg(8'h8e, 8'h10);
    settle;
    check("timer2 low", 16'h0001, {15'h0000, t2Low});
    check("timer2 high", 16'h0000, {15'h0000, t2High});
    altTick = 1'b1;
    settle;
    check("timer2 high alt", 16'h0001, {15'h0000, t2High});
    altTick = 1'b0;
    split = 1'b1;
    writeReg(8'h8e, 8'h20);
    settle;
    check("timer2 split high", 16'h0001, {15'h0000, t2High});
    check("timer2 split low", 16'h0000, {15'h0000, t2Low});
    $display("timer select test done");
    // counter mode: core clock select ignored, only pin falling edges count
    t1Sel = 1'b1;
    reloadByte = 8'h80;
    writeReg(8'h8e, 8'h08);
    settle;
    check("counter mode idle", 16'h00ff, {8'h00, lowByte});
    t1In = 1'b0;
    repeat (5) @(negedge clock);
    check("counter mode edge", 16'h0080, {8'h00, lowByte});
    t1In = 1'b1;
    $display("counter test done");
    results;
  end
endmodule
